// >>> rtl/sram_ctrl.sv
// AHB-Lite driven controller that runs bursts on the burst SRAM bus.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module sram_ctrl #(
   parameter int LANES  = sram_pkg::DEF_LANES,
   parameter int ADDR_W = sram_pkg::DEF_ADDR_W
) (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave port.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Memory pins.
   sram_bus_if.ctrl         bus
);
   import sram_pkg::*;

   localparam int DW = LANES * LANE_BITS;

   if (!(LANES == 2 || LANES == 4) || ADDR_W <= BURST_W ||
       ADDR_W > 32) begin : g_bad_param
      $error("sram_ctrl: LANES must be 2 or 4, ADDR_W 3 to 32");
   end

   // ==========================================================================
   // Bus slave: one wait state on every access
   logic              pend_ff;
   logic              pwrite_ff;
   logic [7:0]        paddr_ff;
   logic              hready_ff;
   logic [31:0]       hrdata_ff;
   logic [1:0]        ctrl_ff;
   logic [31:0]       addr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wpar_ff;
   logic [31:0]       cmd_ff;
   logic [31:0]       rdata_ff [4];
   logic [15:0]       rpar_ff;
   seq_t              state_ff;
   logic              go_ff;
   logic [1:0]        beat_ff;
   logic              cap1_ff;
   logic              cap2_ff;
   logic [1:0]        idx1_ff;
   logic [1:0]        idx2_ff;

   wire               take;
   wire               reg_wr;
   wire               busy;
   wire               cmd_wr;
   wire               is_rdata;
   wire [1:0]         rd_idx;
   wire [31:0]        rd_mux;

   assign take     = hsel & htrans[1] & hready;
   assign reg_wr   = pend_ff & pwrite_ff;
   assign busy     = (state_ff != ST_IDLE) | go_ff | cap1_ff | cap2_ff;
   assign cmd_wr   = reg_wr & (paddr_ff == REG_CMD) & ~busy;
   assign is_rdata = (paddr_ff >= REG_RDATA0) & (paddr_ff <= REG_RDATA3);
   assign rd_idx   = paddr_ff[3:2] - 2'h2;

   // Read decode; unmapped offsets read zero.
   assign rd_mux =
      (paddr_ff == REG_CTRL)   ? {30'h0, ctrl_ff} :
      (paddr_ff == REG_ADDR)   ? addr_ff :
      (paddr_ff == REG_WDATA)  ? wdata_ff :
      (paddr_ff == REG_WPAR)   ? {28'h0, wpar_ff} :
      (paddr_ff == REG_CMD)    ? cmd_ff :
      (paddr_ff == REG_STATUS) ? {30'h0, ctrl_ff[CTRL_SLEEP_BIT], busy} :
      is_rdata                 ? rdata_ff[rd_idx] :
      (paddr_ff == REG_RPAR)   ? {16'h0, rpar_ff} : 32'h0;

   // Address phase capture and single wait-state data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_ff   <= 1'b0;
         pwrite_ff <= 1'b0;
         paddr_ff  <= 8'h00;
         hready_ff <= 1'b1;
         hrdata_ff <= 32'h0000_0000;
      end else begin
         pend_ff   <= take;
         hready_ff <= ~take;
         if (take) begin
            pwrite_ff <= hwrite;
            paddr_ff  <= {haddr[7:2], 2'b00};
         end
         if (pend_ff) begin
            hrdata_ff <= rd_mux;
         end
      end
   end

   // Software registers; a command is refused while one is running.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff  <= CTRL_RESET;
         addr_ff  <= 32'h0000_0000;
         wdata_ff <= 32'h0000_0000;
         wpar_ff  <= 4'h0;
         cmd_ff   <= CMD_RESET;
      end else if (reg_wr) begin
         if (paddr_ff == REG_CTRL)  ctrl_ff  <= hwdata[1:0];
         if (paddr_ff == REG_ADDR)  addr_ff  <= hwdata;
         if (paddr_ff == REG_WDATA) wdata_ff <= hwdata;
         if (paddr_ff == REG_WPAR)  wpar_ff  <= hwdata[3:0];
         if (cmd_wr)                cmd_ff   <= hwdata;
      end
   end

   // ==========================================================================
   // Burst sequencer
   wire               cmd_write;
   wire               cmd_global;
   wire [LANES-1:0]   cmd_lanes;
   wire [1:0]         cmd_len;
   seq_t              nxt_state;
   wire               issue;
   wire               wr_issue;

   assign cmd_write  = cmd_ff[CMD_WRITE_BIT];
   assign cmd_global = cmd_ff[CMD_GLOBAL_BIT];
   assign cmd_lanes  = cmd_ff[CMD_LANES_LSB +: LANES];
   assign cmd_len    = cmd_ff[CMD_LEN_LSB +: 2];

   always_comb begin
      case (state_ff)
         ST_IDLE:  nxt_state = go_ff ? ST_START : ST_IDLE;
         ST_START: nxt_state = (cmd_len == 2'h0) ? ST_DESEL : ST_STEP;
         ST_STEP:  nxt_state = (beat_ff == cmd_len) ? ST_DESEL : ST_STEP;
         ST_DESEL: nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
   end

   assign issue    = (nxt_state == ST_START) | (nxt_state == ST_STEP);
   assign wr_issue = issue & cmd_write;

   // Pin flops take the values of the state about to be shown.
   logic              astb_n_ff;
   logic              cs_n_ff;
   logic              step_n_ff;
   logic              gw_n_ff;
   logic              bwe_n_ff;
   logic [LANES-1:0]  lanes_n_ff;
   logic              doe_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff   <= ST_IDLE;
         go_ff      <= 1'b0;
         beat_ff    <= 2'h0;
         astb_n_ff  <= 1'b1;
         cs_n_ff    <= 1'b1;
         step_n_ff  <= 1'b1;
         gw_n_ff    <= 1'b1;
         bwe_n_ff   <= 1'b1;
         lanes_n_ff <= '1;
         doe_ff     <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         go_ff      <= cmd_wr | (go_ff & (state_ff != ST_IDLE));
         beat_ff    <= (nxt_state == ST_STEP) ? beat_ff + 2'h1 : 2'h0;
         astb_n_ff  <= ~((nxt_state == ST_START) | (nxt_state == ST_DESEL));
         cs_n_ff    <= (nxt_state == ST_DESEL);
         step_n_ff  <= (nxt_state != ST_STEP);
         gw_n_ff    <= ~(wr_issue & cmd_global);
         bwe_n_ff   <= ~(wr_issue & ~cmd_global);
         lanes_n_ff <= wr_issue ? ~cmd_lanes : '1;
         doe_ff     <= wr_issue;
      end
   end

   // Read beats land one cycle after issue; capture at the next edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap1_ff <= 1'b0;
         cap2_ff <= 1'b0;
         idx1_ff <= 2'h0;
         idx2_ff <= 2'h0;
         rpar_ff <= 16'h0000;
         for (int i = 0; i < 4; i++) rdata_ff[i] <= 32'h0000_0000;
      end else begin
         cap1_ff <= issue & ~cmd_write;
         cap2_ff <= cap1_ff;
         idx1_ff <= (nxt_state == ST_STEP) ? beat_ff + 2'h1 : 2'h0;
         idx2_ff <= idx1_ff;
         if (cap2_ff) begin
            rdata_ff[idx2_ff] <= 32'(bus.data_lanes);
            rpar_ff[idx2_ff*4 +: 4] <= 4'(bus.lane_parity_bits);
         end
      end
   end

   // ==========================================================================
   // Outputs, all from flops or tied constants.
   assign hreadyout              = hready_ff;
   assign hrdata                 = hrdata_ff;
   assign hresp                  = 1'b0;
   assign bus.addr               = addr_ff[ADDR_W-1:0];
   assign bus.chip_sel_n         = cs_n_ff;
   assign bus.chip_sel_aux       = ~cs_n_ff;
   assign bus.chip_sel2_n        = cs_n_ff;
   assign bus.cpu_addr_strobe_n  = 1'b1;
   assign bus.ctrl_addr_strobe_n = astb_n_ff;
   assign bus.burst_step_n       = step_n_ff;
   assign bus.byte_wr_en_n       = bwe_n_ff;
   assign bus.lane_wr_strobes_n  = lanes_n_ff;
   assign bus.all_lanes_wr_n     = gw_n_ff;
   assign bus.burst_order        = ctrl_ff[CTRL_ORDER_BIT];
   assign bus.sleep_req          = ctrl_ff[CTRL_SLEEP_BIT];
   assign bus.out_en_n           = doe_ff;
   assign bus.ctl_data_o         = wdata_ff[DW-1:0];
   assign bus.ctl_par_o          = wpar_ff[LANES-1:0];
   assign bus.ctl_data_oe        = doe_ff;

endmodule

// >>> rtl/sram_pkg.sv
// Shared constants, types and helpers for the burst SRAM and its controller.
package sram_pkg;

   // ==========================================================================
   // Geometry
   // Bits of data per byte lane; each lane also carries one parity bit.
   localparam int LANE_BITS  = 8;
   // Width of the burst counter, giving bursts of up to four words.
   localparam int BURST_W    = 2;
   // Default lane count (4 lanes is the wide word, 2 lanes the narrow one).
   localparam int DEF_LANES  = 4;
   // Default word address width of the array.
   localparam int DEF_ADDR_W = 20;

   // ==========================================================================
   // Controller register map (byte offsets on the AHB-Lite port)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_WPAR   = 8'h0c;
   localparam logic [7:0] REG_CMD    = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_RDATA0 = 8'h18;
   localparam logic [7:0] REG_RDATA3 = 8'h24;
   localparam logic [7:0] REG_RPAR   = 8'h28;

   // Field positions.
   localparam int CTRL_ORDER_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int CMD_WRITE_BIT  = 0;
   localparam int CMD_GLOBAL_BIT = 1;
   localparam int CMD_LANES_LSB  = 4;
   localparam int CMD_LEN_LSB    = 8;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_SLEEP_BIT = 1;

   // Reset values: interleaved order, awake; empty command.
   localparam logic [1:0]  CTRL_RESET = 2'h1;
   localparam logic [31:0] CMD_RESET  = 32'h0000_0000;

   // Command sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_STEP  = 2'b10,
      ST_DESEL = 2'b11
   } seq_t;

   // Low address bits of a burst beat: seed plus count, or seed xor count.
   function automatic logic [BURST_W-1:0] burst_lsb(
      input logic [BURST_W-1:0] seed,
      input logic [BURST_W-1:0] cnt,
      input logic               interleave
   );
      return interleave ? (seed ^ cnt) : BURST_W'(seed + cnt);
   endfunction

endpackage

// >>> rtl/sram_bus_if.sv
// Pin bundle between the burst SRAM and its controller.
`timescale 1ns/1ps
interface sram_bus_if #(
   parameter int LANES  = sram_pkg::DEF_LANES,
   parameter int ADDR_W = sram_pkg::DEF_ADDR_W
);
   // ==========================================================================
   // Synchronous control and address
   logic [ADDR_W-1:0]               addr;
   logic                            chip_sel_n;
   logic                            chip_sel_aux;
   logic                            chip_sel2_n;
   logic                            cpu_addr_strobe_n;
   logic                            ctrl_addr_strobe_n;
   logic                            burst_step_n;
   logic                            byte_wr_en_n;
   logic [LANES-1:0]                lane_wr_strobes_n;
   logic                            all_lanes_wr_n;
   logic                            burst_order;
   // Asynchronous controls.
   logic                            out_en_n;
   logic                            sleep_req;
   // Two-way data pins split into output, enable per end.
   logic [LANES*sram_pkg::LANE_BITS-1:0] ctl_data_o;
   logic [LANES-1:0]                ctl_par_o;
   logic                            ctl_data_oe;
   logic [LANES*sram_pkg::LANE_BITS-1:0] dev_data_o;
   logic [LANES-1:0]                dev_par_o;
   logic                            dev_data_oe;
   // Resolved level of the shared wire.
   logic [LANES*sram_pkg::LANE_BITS-1:0] data_lanes;
   logic [LANES-1:0]                lane_parity_bits;

   // The wire follows whichever end enables; an undriven bus reads zero.
   assign data_lanes = dev_data_oe ? dev_data_o :
                       (ctl_data_oe ? ctl_data_o : '0);
   assign lane_parity_bits = dev_data_oe ? dev_par_o :
                             (ctl_data_oe ? ctl_par_o : '0);

   modport device (
      input  addr, chip_sel_n, chip_sel_aux, chip_sel2_n,
      input  cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
      input  byte_wr_en_n, lane_wr_strobes_n, all_lanes_wr_n,
      input  burst_order, out_en_n, sleep_req,
      input  data_lanes, lane_parity_bits,
      output dev_data_o, dev_par_o, dev_data_oe
   );

   modport ctrl (
      output addr, chip_sel_n, chip_sel_aux, chip_sel2_n,
      output cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
      output byte_wr_en_n, lane_wr_strobes_n, all_lanes_wr_n,
      output burst_order, out_en_n, sleep_req,
      output ctl_data_o, ctl_par_o, ctl_data_oe,
      input  data_lanes, lane_parity_bits
   );
endinterface

// >>> rtl/sram_device.sv
// Flow-through synchronous burst SRAM: the memory end of the bus.
`timescale 1ns/1ps
// =============================================================================
module sram_device #(
   parameter int LANES  = sram_pkg::DEF_LANES,
   parameter int ADDR_W = sram_pkg::DEF_ADDR_W
) (
   // Clock and power-up reset.
   input  wire logic  hclk,
   input  wire logic  hresetn,
   // Memory pins.
   sram_bus_if.device bus,
   // Status seen by the system.
   output logic       asleep,
   output logic       deselected
);
   import sram_pkg::*;

   // ==========================================================================
   // Sizes and elaboration check
   localparam int DW    = LANES * LANE_BITS;
   localparam int WA    = ADDR_W - BURST_W;
   localparam int DEPTH = 1 << ADDR_W;

   if (!(LANES == 2 || LANES == 4) || ADDR_W <= BURST_W ||
       ADDR_W > 24) begin : g_bad_param
      $error("sram_device: LANES must be 2 or 4, ADDR_W 3 to 24");
   end

   // ==========================================================================
   // Storage and input registers
   logic [DW-1:0]      mem_d [DEPTH];
   logic [LANES-1:0]   mem_p [DEPTH];

   logic [WA-1:0]      base_ff;
   logic [BURST_W-1:0] seed_ff;
   logic [BURST_W-1:0] cnt_ff;
   logic               act_ff;
   logic               drive_ff;
   logic               order_ff;
   logic               asleep_ff;
   logic               desel_ff;
   logic [LANES-1:0]   wmask_ff;
   logic [DW-1:0]      wdata_ff;
   logic [LANES-1:0]   wpar_ff;

   // ==========================================================================
   // Command decode from the pins of this cycle
   wire               strobe;
   wire               ce_ok;
   wire               start;
   wire               cpu_start;
   wire               desel;
   wire               step;
   wire [LANES-1:0]   byte_mask;
   wire [LANES-1:0]   wr_lanes;
   wire               nxt_act;
   wire [LANES-1:0]   nxt_wmask;
   wire [ADDR_W-1:0]  cur_addr;

   // Either strobe opens an access; chip selects are looked at only then.
   assign strobe    = ~bus.cpu_addr_strobe_n | ~bus.ctrl_addr_strobe_n;
   assign ce_ok     = ~bus.chip_sel_n & bus.chip_sel_aux &
                      ~bus.chip_sel2_n;
   assign start     = strobe & ce_ok & ~bus.sleep_req;
   assign cpu_start = start & ~bus.cpu_addr_strobe_n;
   assign desel     = (strobe & ~ce_ok) | bus.sleep_req;
   assign step      = ~strobe & ~bus.burst_step_n & act_ff;

   // Lane selection: global write wins, else enable with lane strobes.
   // A processor-strobe start is always a read cycle.
   assign byte_mask = bus.byte_wr_en_n ? '0 : ~bus.lane_wr_strobes_n;
   assign wr_lanes  = cpu_start ? '0 :
                      (~bus.all_lanes_wr_n ? '1 : byte_mask);
   assign nxt_act   = start | (act_ff & ~desel);
   assign nxt_wmask = nxt_act ? wr_lanes : '0;

   // Word address of the current beat.
   assign cur_addr  = {base_ff, burst_lsb(seed_ff, cnt_ff, order_ff)};

   // ==========================================================================
   // Clocked control state of the access.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_ff    <= 1'b0;
         drive_ff  <= 1'b0;
         wmask_ff  <= '0;
         order_ff  <= 1'b1;
         asleep_ff <= 1'b0;
         desel_ff  <= 1'b1;
         base_ff   <= '0;
         seed_ff   <= '0;
         cnt_ff    <= '0;
      end else begin
         act_ff    <= nxt_act;
         wmask_ff  <= nxt_wmask;
         drive_ff  <= nxt_act & ~|wr_lanes;
         order_ff  <= bus.burst_order;
         asleep_ff <= bus.sleep_req;
         desel_ff  <= ~nxt_act;
         if (start) begin
            base_ff <= bus.addr[ADDR_W-1:BURST_W];
            seed_ff <= bus.addr[BURST_W-1:0];
            cnt_ff  <= '0;
         end else if (step) begin
            cnt_ff  <= cnt_ff + 1'b1;
         end
      end
   end

   // Write data is registered with its command on the same edge.
   always_ff @(posedge hclk) begin
      wdata_ff <= bus.data_lanes;
      wpar_ff  <= bus.lane_parity_bits;
   end

   // Self-timed array write one edge after the command was sampled.
   always_ff @(posedge hclk) begin
      for (int i = 0; i < LANES; i++) begin
         if (act_ff && wmask_ff[i]) begin
            mem_d[cur_addr][i*LANE_BITS +: LANE_BITS] <=
               wdata_ff[i*LANE_BITS +: LANE_BITS];
            mem_p[cur_addr][i] <= wpar_ff[i];
         end
      end
   end

   // ==========================================================================
   // Flow-through read path and asynchronous output gating.
   assign bus.dev_data_o  = mem_d[cur_addr];
   assign bus.dev_par_o   = mem_p[cur_addr];
   assign bus.dev_data_oe = drive_ff & ~bus.out_en_n &
                            ~bus.sleep_req;

   // Status outputs.
   assign asleep     = asleep_ff;
   assign deselected = desel_ff;

endmodule

// >>> sim/sram_sva.sv
// Pin-level assertions between the burst SRAM and its controller.
`timescale 1ns/1ps
// =============================================================================
// Checker
module sram_sva (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Memory pins.
   input wire logic ctrl_addr_strobe_n,
   input wire logic cpu_addr_strobe_n,
   input wire logic chip_sel_n,
   input wire logic chip_sel_aux,
   input wire logic chip_sel2_n,
   input wire logic burst_step_n,
   input wire logic byte_wr_en_n,
   input wire logic all_lanes_wr_n,
   input wire logic out_en_n,
   input wire logic sleep_req,
   input wire logic ctl_data_oe,
   input wire logic dev_data_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Decoded pin commands.
   wire sel_ok = !chip_sel_n && chip_sel_aux && !chip_sel2_n;
   wire start  = !ctrl_addr_strobe_n && sel_ok && !sleep_req;
   wire wr_cmd = !all_lanes_wr_n || !byte_wr_en_n;
   wire desel  = !ctrl_addr_strobe_n && !sel_ok;

   property p_oe_gate; dev_data_oe |-> !out_en_n; endproperty
   a_oe_gate: assert property (p_oe_gate)
      else $error("Device drove with output enable off.");
   property p_sleep_off; sleep_req |-> !dev_data_oe; endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("Device drove while asleep.");
   property p_one_drv; !(dev_data_oe && ctl_data_oe); endproperty
   a_one_drv: assert property (p_one_drv)
      else $error("Both ends drove the data lanes.");
   property p_desel; desel |=> !dev_data_oe [*2]; endproperty
   a_desel: assert property (p_desel)
      else $error("Drive went on after a deselect.");
   property p_flow;
      start && !wr_cmd |=> dev_data_oe || out_en_n || sleep_req;
   endproperty
   a_flow: assert property (p_flow)
      else $error("Read beat not driven in the next cycle.");
   property p_wr_own;
      start && wr_cmd |-> ctl_data_oe && out_en_n ##1 !dev_data_oe;
   endproperty
   a_wr_own: assert property (p_wr_own)
      else $error("Write beat without controller drive.");
   property p_step; !burst_step_n |-> ctrl_addr_strobe_n; endproperty
   a_step: assert property (p_step)
      else $error("Advance given with a start strobe.");
   property p_cpu; cpu_addr_strobe_n && $stable(cpu_addr_strobe_n);
   endproperty
   a_cpu: assert property (p_cpu)
      else $error("Processor strobe moved.");
   // Main scenarios.
   c_read: cover property (start && !wr_cmd);
   c_write: cover property (start && wr_cmd);
   c_step: cover property (!burst_step_n);
   c_desel: cover property (desel);
endmodule

// >>> sim/sync_burst_sram_flowthrough_bench.sv
// Bench driving the controller over AHB-Lite against the burst SRAM.
`timescale 1ns/1ps
module sync_burst_sram_flowthrough_bench;
   import sram_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        asleep, deselected;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd, par;
   logic [1:0]  seed, lsb;
   int          fail_count, total_checks;

   sram_bus_if #(.LANES(4), .ADDR_W(8)) bus ();
   sram_device #(.LANES(4), .ADDR_W(8)) i_sram_device (.hclk(hclk),
      .hresetn(hresetn), .bus(bus), .asleep(asleep),
      .deselected(deselected));
   sram_ctrl #(.LANES(4), .ADDR_W(8)) i_sram_ctrl (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .bus(bus));
   sram_sva i_sram_sva (.hclk(hclk), .hresetn(hresetn),
      .ctrl_addr_strobe_n(bus.ctrl_addr_strobe_n),
      .cpu_addr_strobe_n(bus.cpu_addr_strobe_n),
      .chip_sel_n(bus.chip_sel_n), .chip_sel_aux(bus.chip_sel_aux),
      .chip_sel2_n(bus.chip_sel2_n), .burst_step_n(bus.burst_step_n),
      .byte_wr_en_n(bus.byte_wr_en_n),
      .all_lanes_wr_n(bus.all_lanes_wr_n), .out_en_n(bus.out_en_n),
      .sleep_req(bus.sleep_req), .ctl_data_oe(bus.ctl_data_oe),
      .dev_data_oe(bus.dev_data_oe));

   // Clock at 50 ns period.
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Waits for an edge that samples hready high, with a bound.
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 20) begin
         n++;
         @(posedge hclk);
      end
      if (hreadyout !== 1'b1) begin
         fail_count++;
         finish_test();
      end
   endtask

   // One single-word AHB-Lite transfer, entered just after an edge.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      d = hrdata;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, rd);
      check(nm, rd, exp);
   endtask

   // Polls the busy flag until the command has finished.
   task automatic wait_idle;
      for (int n = 0; n < 30; n++) begin
         xfer(1'b0, REG_STATUS, 32'h0, rd);
         if (rd[STAT_BUSY_BIT] === 1'b0)
            return;
      end
      fail_count++;
      finish_test();
   endtask

   // Runs one memory command from address, data, parity and command word.
   task automatic mem_cmd(input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] p, c);
      xfer(1'b1, REG_ADDR, {24'h0, a}, rd);
      xfer(1'b1, REG_WDATA, d, rd);
      xfer(1'b1, REG_WPAR, p, rd);
      xfer(1'b1, REG_CMD, c, rd);
      wait_idle();
   endtask

   // Main sequence.
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk("ctrl", REG_CTRL, 32'h1);
      rd_chk("status", REG_STATUS, 32'h0);
      rd_chk("unmapped", 8'h40, 32'h0);
      check("desel", {31'h0, deselected}, 32'h1);
      check("okay", {31'h0, hresp}, 32'h0);
      $display("Test reset values done");
      mem_cmd(8'h10, 32'ha5a5a5a5, 32'hf, 32'h3);
      mem_cmd(8'h10, 32'h11223344, 32'h0, 32'h51);
      mem_cmd(8'h11, 32'h01020304, 32'h5, 32'h3);
      mem_cmd(8'h11, 32'heeeeeeee, 32'hf, 32'h81);
      mem_cmd(8'h10, 32'h0, 32'h0, 32'h100);
      rd_chk("lanes", REG_RDATA0, 32'ha522a544);
      rd_chk("global", REG_RDATA0 + 8'h4, 32'hee020304);
      rd_chk("parity", REG_RPAR, 32'hda);
      $display("Test byte lanes done");
      for (int i = 0; i < 4; i++)
         mem_cmd(8'h20 + 8'(i), 32'hc0de0000 + i, i, 32'h3);
      for (int o = 0; o < 2; o++) begin
         seed = o ? 2'h3 : 2'h2;
         xfer(1'b1, REG_CTRL, o, rd);
         mem_cmd(8'h20 + seed, 32'h0, 32'h0, 32'h300);
         xfer(1'b0, REG_RPAR, 32'h0, par);
         for (int b = 0; b < 4; b++) begin
            lsb = o ? (seed ^ 2'(b)) : (seed + 2'(b));
            rd_chk("beat", REG_RDATA0 + 8'(4 * b), 32'hc0de0000 + lsb);
            check("bpar", {28'h0, par[4*b +: 4]}, {30'h0, lsb});
         end
      end
      check("idle desel", {31'h0, deselected}, 32'h1);
      $display("Test burst order done");
      xfer(1'b1, REG_CTRL, 32'h3, rd);
      rd_chk("sleep", REG_STATUS, 32'h2);
      check("asleep", {31'h0, asleep}, 32'h1);
      xfer(1'b1, REG_CTRL, 32'h1, rd);
      rd_chk("wake", REG_STATUS, 32'h0);
      check("awake", {31'h0, asleep}, 32'h0);
      $display("Test sleep done");
      finish_test();
   end
endmodule
